// >>> pcpc_pkg.sv
package pcpc_pkg;

   // Port geometry
   localparam int unsigned PIN_COUNT    = 6;
   localparam int unsigned ANALOG_COUNT = 4;
   localparam int unsigned REG_WIDTH    = 8;

   // Register word indices; byte address is four times the index
   localparam logic [2:0] IDX_ANALOG_SELECT = 3'h0;
   localparam logic [2:0] IDX_PULLUP_ENABLE = 3'h1;
   localparam logic [2:0] IDX_OUTPUT_LATCH  = 3'h2;
   localparam logic [2:0] IDX_OPTION        = 3'h3;
   localparam logic [2:0] IDX_PIN_DATA      = 3'h4;
   localparam logic [2:0] IDX_DIRECTION     = 3'h5;

   // Bus geometry
   localparam int unsigned ADDR_WIDTH = 5;
   localparam int unsigned DATA_WIDTH = 32;
   localparam logic [1:0]  WORD_ALIGN = 2'h0;

   // Field positions
   localparam int unsigned OPT_PULLUP_DIS_BIT = 7;
   localparam int unsigned BYTE_LANE0         = 0;

   // Reset values
   localparam logic [7:0] RST_ANALOG_SELECT = 8'h0F;
   localparam logic [7:0] RST_PULLUP_ENABLE = 8'h3F;
   localparam logic [7:0] RST_OUTPUT_LATCH  = 8'h00;
   localparam logic [7:0] RST_OPTION        = 8'hFF;
   localparam logic [7:0] RST_DIRECTION     = 8'h3F;

   // Software-visible register file plus bus response state
   typedef struct packed {
      logic [7:0]  analog_select_c;
      logic [7:0]  pullup_enable_c;
      logic [7:0]  output_latch_c;
      logic [7:0]  option_control;
      logic [7:0]  direction_c;
      logic        ack;
      logic [31:0] rdata;
   } pcpc_state_t;

   // Pad control bundle toward the pad ring
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] drive_en;
      logic [7:0] pullup_on;
      logic [7:0] dig_in_en;
      logic [7:0] analog_on;
   } pcpc_pad_ctrl_t;

endpackage

// >>> pcpc_sync.sv
`timescale 1ns/10ps

// Two-stage synchroniser for asynchronous pad levels
module pcpc_sync #(
   parameter int unsigned WIDTH = 6
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } pcpc_sync_state_t;

   pcpc_sync_state_t st;
   pcpc_sync_state_t next_st;

   // Stage one feeds stage two only, nothing else looks at it
   always_comb begin
      next_st        = st;
      next_st.stage1 = async_in;
      next_st.stage2 = st.stage1;
   end

   // Synchronous reset to zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stage2;

endmodule // pcpc_sync

// >>> pcpc_port.sv
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps

module pcpc_port
   import pcpc_pkg::*;
#(
   parameter int unsigned NUM_PINS   = PIN_COUNT,
   parameter int unsigned NUM_ANALOG = ANALOG_COUNT
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // Avalon-MM slave
   input  wire logic [ADDR_WIDTH-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [DATA_WIDTH-1:0] avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output      logic [DATA_WIDTH-1:0] avs_readdata,
   output      logic                  avs_waitrequest,
   // Pad ring
   input  wire logic [NUM_PINS-1:0]   pad_in,
   output      logic [NUM_PINS-1:0]   pad_out,
   output      logic [NUM_PINS-1:0]   pad_oe,
   output      logic [NUM_PINS-1:0]   pad_pullup_en,
   output      logic [NUM_PINS-1:0]   pad_dig_in_en,
   output      logic [NUM_ANALOG-1:0] analog_pin_select
);

   // Elaboration check on geometry the 8-bit registers can hold
   if (NUM_PINS > REG_WIDTH || NUM_PINS == 0) begin : g_bad_pins
      $error("pcpc_port: NUM_PINS must be 1 to 8");
   end
   if (NUM_ANALOG > NUM_PINS) begin : g_bad_analog
      $error("pcpc_port: NUM_ANALOG must not exceed NUM_PINS");
   end

   // Low-ones mask of n implemented bits
   function automatic logic [7:0] low_mask(input int unsigned n);
      logic [8:0] m;
      m = (9'h001 << n) - 9'h001;
      return m[7:0];
   endfunction

   // Widen an 8-bit register image onto the 32-bit bus
   function automatic logic [31:0] to_word(input logic [7:0] v);
      return {24'h000000, v};
   endfunction

   localparam logic [7:0] PIN_MASK    = low_mask(NUM_PINS);
   localparam logic [7:0] ANALOG_MASK = low_mask(NUM_ANALOG);

   pcpc_state_t     st;
   pcpc_state_t     next_st;
   pcpc_pad_ctrl_t  pad;
   logic [NUM_PINS-1:0] pin_sync;
   logic [7:0]      pin_wide;
   logic [7:0]      pin_read;
   logic [2:0]      reg_idx;
   logic            aligned;
   logic            req;
   logic            wr_take;
   logic            lane0;
   logic [7:0]      wbyte;

   // Pads are asynchronous to clk
   pcpc_sync #(
      .WIDTH (NUM_PINS)
   ) u_pin_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in (pad_in),
      .sync_out (pin_sync)
   );

   // Bus decode
   assign reg_idx = avs_address[ADDR_WIDTH-1:2];
   assign aligned = (avs_address[1:0] == WORD_ALIGN);
   assign req     = avs_read | avs_write;
   assign lane0   = avs_byteenable[BYTE_LANE0];
   assign wbyte   = avs_writedata[7:0];
   // Write lands on the edge where waitrequest is seen low
   assign wr_take = avs_write & st.ack & aligned & lane0;

   // One wait cycle, then release for one cycle
   assign avs_waitrequest = req & ~st.ack;
   assign avs_readdata    = st.rdata;

   // Pad control derivation
   always_comb begin
      pin_wide      = 8'h00;
      pin_wide[NUM_PINS-1:0] = pin_sync;
      pad           = '0;
      // Direction 1 is input, so drive only on 0
      pad.drive     = st.output_latch_c & PIN_MASK;
      pad.drive_en  = ~st.direction_c & PIN_MASK;
      pad.analog_on = st.analog_select_c & ANALOG_MASK;
      // Analog pins lose the digital input buffer
      pad.dig_in_en = ~pad.analog_on & PIN_MASK;
      // Global disable bit off, pin requested, pin not an output
      pad.pullup_on = st.pullup_enable_c
                    & {8{~st.option_control[OPT_PULLUP_DIS_BIT]}}
                    & st.direction_c
                    & PIN_MASK;
      // Read path sees pad level only where the buffer is on
      pin_read      = pin_wide & pad.dig_in_en;
   end

   // Register file and bus response
   always_comb begin
      next_st       = st;
      // Ack pulses for exactly one cycle per request
      next_st.ack   = req & ~st.ack;
      if (req && !st.ack) begin
         // Capture read data on the same edge the ack rises
         next_st.rdata = 32'h00000000;
         if (avs_read && aligned) begin
            case (reg_idx)
               IDX_ANALOG_SELECT: begin
                  next_st.rdata = to_word(st.analog_select_c & ANALOG_MASK);
               end
               IDX_PULLUP_ENABLE: begin
                  next_st.rdata = to_word(st.pullup_enable_c & PIN_MASK);
               end
               IDX_OUTPUT_LATCH: begin
                  next_st.rdata = to_word(st.output_latch_c & PIN_MASK);
               end
               IDX_OPTION: begin
                  next_st.rdata = to_word(st.option_control);
               end
               IDX_PIN_DATA: begin
                  next_st.rdata = to_word(pin_read);
               end
               IDX_DIRECTION: begin
                  next_st.rdata = to_word(st.direction_c & PIN_MASK);
               end
               default: begin
                  // Unmapped words read as zero
                  next_st.rdata = 32'h00000000;
               end
            endcase
         end
      end
      // Writes keep only implemented bits
      if (wr_take) begin
         case (reg_idx)
            IDX_ANALOG_SELECT: begin
               next_st.analog_select_c = wbyte & ANALOG_MASK;
            end
            IDX_PULLUP_ENABLE: begin
               next_st.pullup_enable_c = wbyte & PIN_MASK;
            end
            IDX_OUTPUT_LATCH: begin
               next_st.output_latch_c  = wbyte & PIN_MASK;
            end
            IDX_OPTION: begin
               next_st.option_control  = wbyte;
            end
            IDX_PIN_DATA: begin
               // Port writes go to the latch, not the pins
               next_st.output_latch_c  = wbyte & PIN_MASK;
            end
            IDX_DIRECTION: begin
               next_st.direction_c     = wbyte & PIN_MASK;
            end
            default: begin
               // Unmapped writes are dropped
               next_st = next_st;
            end
         endcase
      end
   end

   // State register, synchronous active-low reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st.analog_select_c <= RST_ANALOG_SELECT;
         st.pullup_enable_c <= RST_PULLUP_ENABLE;
         st.output_latch_c  <= RST_OUTPUT_LATCH;
         st.option_control  <= RST_OPTION;
         st.direction_c     <= RST_DIRECTION;
         st.ack             <= 1'b0;
         st.rdata           <= 32'h00000000;
      end else begin
         st <= next_st;
      end
   end

   // Pad outputs, all combinational from registered state
   assign pad_out           = pad.drive[NUM_PINS-1:0];
   assign pad_oe            = pad.drive_en[NUM_PINS-1:0];
   assign pad_pullup_en     = pad.pullup_on[NUM_PINS-1:0];
   assign pad_dig_in_en     = pad.dig_in_en[NUM_PINS-1:0];
   assign analog_pin_select = pad.analog_on[NUM_ANALOG-1:0];

endmodule // pcpc_port

// >>> pcpc_port_asserts.sv
`timescale 1ns/10ps

// Pad output invariants, bus wait and read data, and pad outputs after accepted bus writes
module pcpc_port_chk (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [5:0]  pad_oe,
   input wire logic [5:0]  pad_pullup_en,
   input wire logic [5:0]  pad_dig_in_en,
   input wire logic [3:0]  analog_pin_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Write that lands at this edge; lane 0 off means dropped
   wire logic acc = avs_write && !avs_waitrequest && avs_byteenable[0];
   a_pullup_out_off: assert property (!(|(pad_pullup_en & pad_oe)))
      else $error("pull-up on driven pin");
   a_analog_buf_off: assert property (pad_dig_in_en[3:0] == ~analog_pin_select)
      else $error("input buffer disagrees with analog select");
   a_high_buf_on: assert property (pad_dig_in_en[5:4] == 2'h3)
      else $error("upper pin buffer off");
   a_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait not one cycle");
   a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_analog_write: assert property (acc && avs_address == 5'h00
      |=> analog_pin_select == $past(avs_writedata[3:0])) else $error("analog select not loaded");
   a_dir_write: assert property (acc && avs_address == 5'h14
      |=> pad_oe == ~$past(avs_writedata[5:0])) else $error("drive enable wrong");
   a_global_off: assert property (acc && avs_address == 5'h0C && avs_writedata[7]
      |=> pad_pullup_en == 6'h00) else $error("pull-up on while disabled");
endmodule // pcpc_port_chk

bind pcpc_port pcpc_port_chk u_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
   .pad_dig_in_en(pad_dig_in_en), .analog_pin_select(analog_pin_select));

// >>> testbench.sv
`timescale 1ns/10ps

module testbench;
   logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic [3:0]  be = 4'hF, p_an;
   logic [5:0]  pad_in = 6'h00, p_out, p_oe, p_pu, p_din;
   logic [7:0]  q;
   int          err_total = 0, n_tests = 0, cyc = 0;
   // Table rows: address, value written, value read back
   logic [4:0]  ra [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h14, 5'h18};
   logic [7:0]  rw [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'hFF, 8'hFF};
   logic [7:0]  re [6] = '{8'h0F, 8'h3F, 8'h3F, 8'h5A, 8'h3F, 8'h00};
   logic [7:0]  rv [5] = '{pcpc_pkg::RST_ANALOG_SELECT, pcpc_pkg::RST_PULLUP_ENABLE,
      pcpc_pkg::RST_OUTPUT_LATCH, pcpc_pkg::RST_OPTION, pcpc_pkg::RST_DIRECTION};

   pcpc_port dut (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wreq), .pad_in(pad_in), .pad_out(p_out), .pad_oe(p_oe),
      .pad_pullup_en(p_pu), .pad_dig_in_en(p_din), .analog_pin_select(p_an));

   always #20 clk = ~clk;

   // Hang guard, far above the hundred or so cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         end_of_test();
      end
   end

   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One bus cycle, held until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b);
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h0, d};
      be <= b;
      // Sample before this edge's updates land, so read data is the standing value
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task rdchk(input string nm, input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'hF);
      chk(nm, e, q);
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, ra[i], rw[i], 4'hF);
         rdchk("reg", ra[i], re[i]);
      end
      $display("test register table done");
      // Global enable on, pins 4 and 5 driven
      bus(1'b1, 5'h0C, 8'h00, 4'hF);
      bus(1'b1, 5'h04, 8'h3F, 4'hF);
      bus(1'b1, 5'h14, 8'h0F, 4'hF);
      @(negedge clk);
      chk("pullup", 8'h0F, {2'h0, p_pu});
      chk("oe", 8'h30, {2'h0, p_oe});
      bus(1'b1, 5'h0C, 8'h80, 4'hF);
      @(negedge clk);
      chk("pullup_off", 8'h00, {2'h0, p_pu});
      $display("test pull-up gating done");
      // Analog pins read low even with the pad high
      bus(1'b1, 5'h00, 8'h05, 4'hF);
      bus(1'b1, 5'h14, 8'h3F, 4'hF);
      pad_in <= 6'h3F;
      repeat (4) @(posedge clk);
      rdchk("pin_data", 5'h10, 8'h3A);
      chk("dig_in_en", 8'h3A, {2'h0, p_din});
      // Lane 0 off drops the write; pin data write loads the latch
      bus(1'b1, 5'h00, 8'h0A, 4'hE);
      rdchk("lane_off", 5'h00, 8'h05);
      bus(1'b1, 5'h10, 8'h15, 4'hF);
      rdchk("latch", 5'h08, 8'h15);
      @(negedge clk);
      chk("pad_out", 8'h15, {2'h0, p_out});
      $display("test analog and latch done");
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rdchk("reset", ra[i], rv[i]);
      end
      $display("test second reset done");
      end_of_test();
   end
endmodule // testbench
